// >>> core/hcie_defines.svh
// hcie_defines.svh: command codes, field positions, reset values of the
// host-controller cpu interrupt status/enable block.
// assumes a 16-bit command/data register port driven by the local processor.
`ifndef HCIE_DEFINES_SVH
`define HCIE_DEFINES_SVH

// command codes: read code has bit 7 clear, write code has bit 7 set
`define HCIE_CMD_STATUS_RD 8'h24
`define HCIE_CMD_STATUS_WR 8'hA4
`define HCIE_CMD_ENABLE_RD 8'h25
`define HCIE_CMD_ENABLE_WR 8'hA5

// event bit positions, shared by status and enable
`define HCIE_BIT_FRAME_START 0
`define HCIE_BIT_ISO_LIST0 1
`define HCIE_BIT_ISO_LIST1 2
`define HCIE_BIT_END_OF_XFER 3
`define HCIE_BIT_OPER_REG 4
`define HCIE_BIT_SUSPENDED 5
`define HCIE_BIT_CLOCK_READY 6
`define HCIE_BIT_PERIODIC 7
`define HCIE_BIT_ASYNC 8
`define HCIE_BIT_DUAL_ROLE 9

`define HCIE_NUM_EVENTS 10
`define HCIE_EVENT_RESET 10'h000
`define HCIE_ENABLE_RESET 10'h000
`define HCIE_GLOBAL_EN_BIT 0

`endif

// >>> core/hcie_pkg.sv
// hcie_pkg.sv: types of the host-controller cpu interrupt block.
// assumes hcie_defines.svh is on the include path.
`default_nettype none
`include "hcie_defines.svh"

package hcie_pkg;

  typedef logic [`HCIE_NUM_EVENTS-1:0] hcie_event_type;

  // one register-port access, one cycle long
  typedef struct packed {
    logic valid;
    logic [7:0] command;
    logic [15:0] wdata;
  } hcie_req_type;

  // answer to a read command
  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } hcie_rsp_type;

endpackage : hcie_pkg

`default_nettype wire

// >>> core/hcie_sticky_bit.sv
// hcie_sticky_bit.sv: one event flag; a hardware set wins over a write clear.
// assumes event pulses and writes come from logic on i_clock.
`default_nettype none

module hcie_sticky_bit (
  input wire logic i_clock, // system clock
  input wire logic i_reset_n, // synchronous reset, active low
  input wire logic i_set, // hardware event pulse
  input wire logic i_clear, // software write-one-to-clear
  output logic o_flag // sticky flag
);

  logic flag_d;

  assign flag_d = i_set | (o_flag & ~i_clear);

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= flag_d;
    end
  end

  set_wins_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_set |=> o_flag)
    else $error("event lost against a clear");

endmodule : hcie_sticky_bit

`default_nettype wire

// >>> core/hcie_top.sv
// hcie_top.sv: status and enable registers of the host-controller cpu
// interrupt, and the combined interrupt request output.
// assumes event pulses arrive one cycle wide from host-controller logic on
// i_clock, and the global enable bit comes from the hardware_setup register.
//
// Functional notes
// - iso_list1_done, bit 2, sets when the second iso buffer's last descriptor finishes.
// - iso_list0_done, bit 1, sets when the first iso buffer's last descriptor finishes.
// - frame_start_event, bit 0, sets when the controller enters start-of-frame.
// - enable bits 9..0 map one-for-one onto the status event bits.
// - every enable is qualified by hardware_setup bit 0, the global enable.
// - all enable bits reset to zero, so no interrupt until software enables.
// - writing one enables an event's interrupt; zero keeps it masked.
// - enable register read with command 25 hex, written with A5 hex.
// - enable bits 9,8,7,6,5 unmask dual-role, async, periodic, clock-ready, suspended.
// - enable bits 4,3,2,1,0 unmask oper-reg, end-of-transfer, iso1, iso0, frame-start.
// - dual-role event sets bit 9; software then reads dual_role_irq_status.
// - async-list bit 8 sets on done-count or timeout threshold reached.
// - end-of-transfer bit 3 sets on transfer_count zero or external pin.
// - clock-ready bit 6 sets after wake from suspend with clock running.
`default_nettype none
`include "hcie_defines.svh"

module hcie_top (
  input wire logic i_clock, // 100 MHz system clock
  input wire logic i_reset_n, // synchronous reset, active low
  input wire hcie_pkg::hcie_req_type i_req, // register command port
  output hcie_pkg::hcie_rsp_type o_rsp, // read answer, one cycle later
  input wire logic i_global_enable, // hardware_setup bit 0
  input wire logic i_frame_start, // start-of-frame state entered
  input wire logic i_iso_list0_done, // last descriptor of iso_buffer_a done
  input wire logic i_iso_list1_done, // last descriptor of iso_buffer_b done
  input wire logic i_transfer_count_zero, // transfer_count reached zero
  input wire logic i_eot_pin, // external end-of-transfer pin, async
  input wire logic i_oper_reg_event, // operational register interrupt
  input wire logic i_suspended, // controller entered suspend
  input wire logic i_clock_ready, // woke from suspend, clock running
  input wire logic i_periodic_done, // periodic list done with ack
  input wire logic i_async_count_hit, // async_done_count_threshold reached
  input wire logic i_async_timeout_hit, // async_done_timeout reached
  input wire logic i_dual_role_event, // dual-role event pending
  output logic o_interrupt // interrupt_output_pin request
);
  import hcie_pkg::*;

  // ==========================================================================
  // external pin synchroniser and edge detect
  // ==========================================================================
  logic eot_meta_q;
  logic eot_sync_q;
  logic eot_last_q;
  wire logic eot_rise;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      eot_meta_q <= 1'b0;
      eot_sync_q <= 1'b0;
      eot_last_q <= 1'b0;
    end else begin
      eot_meta_q <= i_eot_pin;
      eot_sync_q <= eot_meta_q;
      eot_last_q <= eot_sync_q;
    end
  end

  assign eot_rise = eot_sync_q & ~eot_last_q;

  // ==========================================================================
  // event sources
  // ==========================================================================
  hcie_event_type event_set;

  assign event_set[`HCIE_BIT_FRAME_START] = i_frame_start;
  assign event_set[`HCIE_BIT_ISO_LIST0] = i_iso_list0_done;
  assign event_set[`HCIE_BIT_ISO_LIST1] = i_iso_list1_done;
  assign event_set[`HCIE_BIT_END_OF_XFER] = i_transfer_count_zero | eot_rise;
  assign event_set[`HCIE_BIT_OPER_REG] = i_oper_reg_event;
  assign event_set[`HCIE_BIT_SUSPENDED] = i_suspended;
  assign event_set[`HCIE_BIT_CLOCK_READY] = i_clock_ready;
  assign event_set[`HCIE_BIT_PERIODIC] = i_periodic_done;
  assign event_set[`HCIE_BIT_ASYNC] = i_async_count_hit | i_async_timeout_hit;
  assign event_set[`HCIE_BIT_DUAL_ROLE] = i_dual_role_event;

  // ==========================================================================
  // command decode
  // ==========================================================================
  function automatic logic cmd_is(input hcie_req_type req, input logic [7:0] code);
    cmd_is = req.valid && (req.command == code);
  endfunction : cmd_is

  wire logic status_wr;
  wire logic enable_wr;
  wire logic status_rd;
  wire logic enable_rd;

  assign status_wr = cmd_is(i_req, `HCIE_CMD_STATUS_WR);
  assign enable_wr = cmd_is(i_req, `HCIE_CMD_ENABLE_WR);
  assign status_rd = cmd_is(i_req, `HCIE_CMD_STATUS_RD);
  assign enable_rd = cmd_is(i_req, `HCIE_CMD_ENABLE_RD);

  // ==========================================================================
  // status flags: write one to clear, set wins
  // ==========================================================================
  hcie_event_type status_flags;
  hcie_event_type status_clear;

  assign status_clear = status_wr ? i_req.wdata[`HCIE_NUM_EVENTS-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < `HCIE_NUM_EVENTS; gi++) begin : g_flag
      hcie_sticky_bit u_flag (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_set(event_set[gi]),
        .i_clear(status_clear[gi]),
        .o_flag(status_flags[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // enable register
  // ==========================================================================
  hcie_event_type enable_q;
  hcie_event_type enable_d;

  // bits 15..10 are reserved and dropped on write
  assign enable_d = enable_wr ? i_req.wdata[`HCIE_NUM_EVENTS-1:0] : enable_q;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      enable_q <= `HCIE_ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  // ==========================================================================
  // read path
  // ==========================================================================
  hcie_rsp_type rsp_q;
  hcie_rsp_type rsp_d;
  wire logic [15:0] rd_word;

  // unknown read codes answer zero so the bus never floats
  assign rd_word = status_rd ? {6'h00, status_flags} :
                   enable_rd ? {6'h00, enable_q} : 16'h0000;
  assign rsp_d.valid = i_req.valid & ~i_req.command[7];
  assign rsp_d.rdata = rd_word;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign o_rsp = rsp_q;

  // ==========================================================================
  // interrupt request
  // ==========================================================================
  wire logic irq_d;
  logic irq_q;

  // bitwise pairing keeps each enable tied to its own event
  assign irq_d = i_global_enable & |(status_flags & enable_q);

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign o_interrupt = irq_q;

  // ==========================================================================
  // checks
  // ==========================================================================
  irq_follows_cause_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_global_enable && |(status_flags & enable_q)) |=> o_interrupt)
    else $error("interrupt missing for enabled pending event");

  irq_needs_global_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !i_global_enable |=> !o_interrupt)
    else $error("interrupt without global enable");

  enable_reset_zero_a: assert property (@(posedge i_clock)
    !i_reset_n |=> (enable_q == 10'h000) && !o_interrupt)
    else $error("enable not zero after reset");

  enable_write_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    enable_wr |=> enable_q == $past(i_req.wdata[9:0]))
    else $error("enable write not stored");

  enable_hold_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !enable_wr |=> $stable(enable_q))
    else $error("enable changed without write command");

  enable_read_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    enable_rd |=> o_rsp.valid && o_rsp.rdata == {6'h00, $past(enable_q)})
    else $error("enable read wrong");

  masked_no_irq_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ((status_flags & enable_q) == 10'h000) |=> !o_interrupt)
    else $error("interrupt from masked event");

  frame_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_frame_start |=> status_flags[0])
    else $error("frame start flag not set");

  iso_flags_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_iso_list0_done || i_iso_list1_done) |=>
      (status_flags[1] || !$past(i_iso_list0_done)) &&
      (status_flags[2] || !$past(i_iso_list1_done)))
    else $error("iso list flag not set");

  eot_pin_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    $rose(i_eot_pin) ##0 i_reset_n [*3] |-> ##3 status_flags[3])
    else $error("eot pin did not set flag");

  async_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_async_count_hit || i_async_timeout_hit) |=> status_flags[8])
    else $error("async flag not set");

  dual_clock_flags_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_dual_role_event || i_clock_ready) |=>
      (status_flags[9] || !$past(i_dual_role_event)) &&
      (status_flags[6] || !$past(i_clock_ready)))
    else $error("dual-role or clock-ready flag not set");

  // ==========================================================================
  // checks on the remaining flags and the read port
  // ==========================================================================
  oper_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_oper_reg_event |=> status_flags[4])
    else $error("operational register flag not set");

  suspend_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_suspended |=> status_flags[5])
    else $error("suspended flag not set");

  periodic_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_periodic_done |=> status_flags[7])
    else $error("periodic list flag not set");

  count_zero_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_transfer_count_zero |=> status_flags[3])
    else $error("transfer count flag not set");

  eot_single_pulse_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    eot_rise |=> !eot_rise)
    else $error("pin edge detected twice");

  flag_keep_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !status_wr |=> (status_flags & $past(status_flags)) == $past(status_flags))
    else $error("flag dropped without a clear");

  flag_clear_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    status_wr |=> (status_flags & $past(status_clear) & ~$past(event_set)) == 10'h000)
    else $error("flag not cleared by write");

  flag_reset_a: assert property (@(posedge i_clock)
    !i_reset_n |=> status_flags == 10'h000)
    else $error("flags not zero after reset");

  status_read_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    status_rd |=> o_rsp.valid && o_rsp.rdata == {6'h00, $past(status_flags)})
    else $error("status read wrong");

  unknown_read_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_req.valid && !i_req.command[7] && !status_rd && !enable_rd) |=>
      o_rsp.valid && o_rsp.rdata == 16'h0000)
    else $error("unknown read code did not answer zero");

  idle_no_rsp_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !(i_req.valid && !i_req.command[7]) |=> !o_rsp.valid)
    else $error("answer without a read command");

  reserved_zero_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    o_rsp.valid |-> o_rsp.rdata[15:10] == 6'h00)
    else $error("reserved read bits not zero");

  rsp_reset_a: assert property (@(posedge i_clock)
    !i_reset_n |=> !o_rsp.valid)
    else $error("answer pending after reset");

endmodule : hcie_top

`default_nettype wire

// >>> dv/hcie_cpu_model.sv
// hcie_cpu_model.sv: processor side of the register command port.
// assumes the block answers a read on the same edge that takes it.
// never starts an iso dma transfer, so dma_setup needs no set-up first
`default_nettype none

module hcie_cpu_model (
  input wire logic i_clock, // system clock
  output hcie_pkg::hcie_req_type o_req, // command to the block
  input wire hcie_pkg::hcie_rsp_type i_rsp // read answer
);
  import hcie_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  initial o_req = '0;

  // ==========================================================
  // bus cycles
  // one-cycle strobe; idle fields are inverted so stale words never pass
  task automatic access(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge i_clock);
    o_req <= '{1'b1, cmd, data};
    @(posedge i_clock);
    o_req <= '{1'b0, ~cmd, ~data};
  endtask : access

  // a missing answer returns unknowns so the caller's compare fails
  task automatic read(input logic [7:0] cmd, output logic [15:0] data);
    access(cmd, 16'h0000);
    #1;
    data = (i_rsp.valid === 1'b1) ? i_rsp.rdata : 16'hXXXX;
  endtask : read
endmodule : hcie_cpu_model

`default_nettype wire

// >>> dv/hcie_top_test.sv
// hcie_top_test.sv: self-checking bench of the cpu interrupt status/enable block.
// assumes hcie_cpu_model plays the processor on the register port.
`default_nettype none

module hcie_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import hcie_pkg::*;

  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic glob = 1'b0;
  logic [11:0] ev = '0;
  hcie_req_type req;
  hcie_rsp_type rsp;
  logic irq;
  logic [15:0] rd;
  logic [15:0] wd;
  logic [15:0] m;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  integer seed = 1;

  initial begin
    forever #5 i_clock = ~i_clock;
  end

  hcie_top i_hcie_top (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_req(req), .o_rsp(rsp),
    .i_global_enable(glob), .i_frame_start(ev[0]), .i_iso_list0_done(ev[1]),
    .i_iso_list1_done(ev[2]), .i_transfer_count_zero(ev[3]), .i_eot_pin(ev[4]),
    .i_oper_reg_event(ev[5]), .i_suspended(ev[6]), .i_clock_ready(ev[7]),
    .i_periodic_done(ev[8]), .i_async_count_hit(ev[9]),
    .i_async_timeout_hit(ev[10]), .i_dual_role_event(ev[11]), .o_interrupt(irq)
  );

  hcie_cpu_model i_hcie_cpu_model (.i_clock(i_clock), .o_req(req), .i_rsp(rsp));

  // ==========================================================
  // expectations and compares
  // event input index to status bit: two inputs share bit 3 and bit 8
  function automatic int bit_of(input int i);
    bit_of = (i <= 4) ? ((i == 4) ? 3 : i) : ((i <= 9) ? i - 1 : ((i == 10) ? 8 : 9));
  endfunction : bit_of

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic finish_test;
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // whole run needs well under a thousand cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    i_hcie_cpu_model.read(8'h25, rd);
    cmp_word(rd, 16'h0000);
    i_hcie_cpu_model.read(8'h24, rd);
    cmp_word(rd, 16'h0000);
    cmp_bit(irq, 1'b0);
    for (int k = 0; k < 8; k++) begin
      wd = 16'($random(seed));
      i_hcie_cpu_model.access(8'hA5, wd);
      i_hcie_cpu_model.read(8'h25, rd);
      cmp_word(rd, wd & 16'h03FF);
    end
    // a write code of another register must leave the enables alone
    i_hcie_cpu_model.access(8'hA8, 16'h0000);
    i_hcie_cpu_model.read(8'h25, rd);
    cmp_word(rd, wd & 16'h03FF);
    @(posedge i_clock);
    glob <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      m = 16'h0001 << bit_of(i);
      i_hcie_cpu_model.access(8'hA5, m);
      @(posedge i_clock);
      ev[i] <= 1'b1;
      @(posedge i_clock);
      ev[i] <= 1'b0;
      // the end-of-transfer pin goes through a synchroniser first
      repeat ((i == 4) ? 4 : 2) @(posedge i_clock);
      #1;
      cmp_bit(irq, 1'b1);
      i_hcie_cpu_model.read(8'h2C, rd);
      cmp_word(rd, 16'h0000);
      i_hcie_cpu_model.read(8'h24, rd);
      cmp_word(rd, m);
      @(posedge i_clock);
      glob <= 1'b0;
      repeat (2) @(posedge i_clock);
      #1;
      cmp_bit(irq, 1'b0);
      @(posedge i_clock);
      glob <= 1'b1;
      i_hcie_cpu_model.access(8'hA5, ~m);
      repeat (2) @(posedge i_clock);
      #1;
      cmp_bit(irq, 1'b0);
      i_hcie_cpu_model.access(8'hA4, m);
      i_hcie_cpu_model.read(8'h24, rd);
      cmp_word(rd, 16'h0000);
    end
    // mid-run reset must clear the enables left set above
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    i_hcie_cpu_model.read(8'h25, rd);
    cmp_word(rd, 16'h0000);
    cmp_bit(irq, 1'b0);
    finish_test();
  end
endmodule : hcie_top_test

`default_nettype wire
